/* pkg/ppp_map.svh */
// Purpose: Named codes, addresses, reset values and timing for the parallel programming port.
// Assumes: Included by bare name wherever the codes are needed; 125 MHz system clock.
// Notes: Pin-level encodings are kept exactly as the programmer drives them.
// Notes on behaviour
// - Signature space holds calibration bytes: 3V at 0x0001, 5V at 0x0003.
// - Every reset copies the 3V calibration byte into the oscillator calibration register.
// - Flash pages: 64 words (word in PC[5:0]) small parts, 128 words largest.
// - EEPROM pages: 4 bytes (EEA[1:0]) small parts, 8 bytes largest part.
// - Ready/busy is low during erase or programming, high when ready.
// - Data bus is driven only while output enable is low.
// - A write or output-enable low pulse runs the last loaded command.
// - Strobe action code: 00 address, 01 data, 10 command, 11 nothing.
// - Byte-select bits choose address, data, fuse or fuse/lock byte.
// - Command bytes decode to erase, writes and reads as listed.
// - Select pins stable 100ns after high voltage, or entry fails.
// - Command and address registers persist across operations.
// - Chip erase clears flash, EEPROM, then locks; fuses untouched.
// - Programmed EEPROM-preserve fuse keeps EEPROM through chip erase.
// - Erase: load command 1000 0000, write pulse starts it, busy until done.
// - Page-load pulse with byte-select low bit high latches data into page buffer.
// - Loading command 0000 0000 resets write signals and ends page programming.
`ifndef PPP_MAP_SVH
`define PPP_MAP_SVH
`define PPP_CMD_NOOP 8'h00
`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_WR_FUSE 8'h40
`define PPP_CMD_WR_LOCK 8'h20
`define PPP_CMD_WR_FLASH 8'h10
`define PPP_CMD_WR_EEP 8'h11
`define PPP_CMD_RD_SIG 8'h08
`define PPP_CMD_RD_FUSE 8'h04
`define PPP_CMD_RD_FLASH 8'h02
`define PPP_CMD_RD_EEP 8'h03
`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2
`define PPP_ACT_IDLE 2'h3
`define PPP_BS_LOW 2'h0
`define PPP_BS_HIGH 2'h1
`define PPP_BS_EXT 2'h2
`define PPP_CAL3V_ADDR 24'h000001
`define PPP_CAL5V_ADDR 24'h000003
`define PPP_OSC_CALIBRATION_REG_RST 8'h00
`define PPP_ENTRY_TOGGLES 3'h6
`define PPP_CLK_NS 8
`define PPP_STABLE_NS 100
`define PPP_STABLE_CYC ((`PPP_STABLE_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS)
`define PPP_PULSE_NS 250
`define PPP_FLASH_WB_SMALL 6
`define PPP_FLASH_WB_LARGE 7
`define PPP_EEP_WB_SMALL 2
`define PPP_EEP_WB_LARGE 3
`endif

/* pkg/ppp_pkg.sv */
// Purpose: Types shared by the parallel programming port, its memory model and bench.
// Assumes: Codes come from ppp_map.svh.
// Notes: Memory requests travel as one packed struct.
`include "ppp_map.svh"
package ppp_pkg;
  typedef enum logic [3:0] {
    OP_RD_FLASH, OP_RD_EEP, OP_RD_SIG, OP_RD_FUSE,
    OP_LOAD_FLASH, OP_LOAD_EEP, OP_PROG_FLASH, OP_PROG_EEP,
    OP_WR_FUSE, OP_WR_LOCK, OP_ERASE_FLASH, OP_ERASE_EEP, OP_CLEAR_LOCK
  } ppp_op_t;

  typedef struct packed {
    ppp_op_t op;
    logic [1:0] sel;
    logic [23:0] page;
    logic [7:0] word;
    logic [15:0] data;
  } ppp_req_t;

  typedef struct packed {
    logic rst_low;
    logic hv;
    logic strobe;
    logic [1:0] act;
    logic bs_hi;
    logic bs_lo;
    logic page_load;
    logic wr_n;
    logic oe_n;
    logic [7:0] data;
  } ppp_pins_t;

  // Reads wait for returned data rather than a completion pulse.
  function automatic logic ppp_is_read(ppp_op_t op);
    return op inside {OP_RD_FLASH, OP_RD_EEP, OP_RD_SIG, OP_RD_FUSE};
  endfunction

  // Page-buffer loads complete as soon as the buffer takes them.
  function automatic logic ppp_is_load(ppp_op_t op);
    return op inside {OP_LOAD_FLASH, OP_LOAD_EEP};
  endfunction
endpackage

/* core/ppp_buf2.sv */
// Purpose: Two-entry buffer between the programming port and the memory controller.
// Assumes: Both sides on mclk_i; head entry always sits in out_data_o.
// Notes: A stall by the memory side fills it, then in_ready_o drops.
module ppp_buf2 #(
  parameter int W = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  logic [1:0] count;
  logic [W-1:0] slot1;
  logic [1:0] next_count;
  wire logic push = in_valid_i & in_ready_o;
  wire logic pop = out_valid_o & out_ready_i;

  // Occupancy after this cycle's push and pop.
  assign in_ready_o = (count != 2'h2);
  assign next_count = 2'(count + {1'b0, push} - {1'b0, pop});

  // Head stays in a flop so the output never passes through a mux.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= 2'h0;
      out_valid_o <= 1'b0;
      out_data_o <= '0;
      slot1 <= '0;
    end else begin
      count <= next_count;
      out_valid_o <= (next_count != 2'h0);
      if (pop) begin
        out_data_o <= (count == 2'h2) ? slot1 : in_data_i;
      end else if (count == 2'h0) begin
        out_data_o <= in_data_i;
      end
      if (push && ((count == 2'h1 && !pop) || (count == 2'h2 && pop))) begin
        slot1 <= in_data_i;
      end
    end
  end
endmodule

/* core/ppp_port.sv */
// Purpose: Device side of the parallel programming port: entry, loading, commands, busy.
// Assumes: Pins are asynchronous to mclk_i; memory controller shares mclk_i.
// Notes: All memory work is requested through a two-entry buffer.
`include "ppp_map.svh"
module ppp_port #(
  parameter bit LARGE_PART = 1'b0
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic rst_pin_low_i,
  input wire logic rst_pin_hv_i,
  input wire logic load_strobe_i,
  input wire logic action_select_0_i,
  input wire logic action_select_1_i,
  input wire logic byte_select_lo_i,
  input wire logic byte_select_hi_i,
  input wire logic page_load_strobe_i,
  input wire logic wr_n_i,
  input wire logic oe_n_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic ready_busy_out_o,
  output logic prog_mode_o,
  output logic [7:0] osc_calibration_reg_o,
  input wire logic eeprom_preserve_fuse_n_i,
  output ppp_pkg::ppp_req_t mem_req_o,
  output logic mem_valid_o,
  input wire logic mem_ready_i,
  input wire logic mem_done_i,
  input wire logic mem_rvalid_i,
  input wire logic [7:0] mem_rdata_i
);
  import ppp_pkg::*;

  localparam int FWB = LARGE_PART ? `PPP_FLASH_WB_LARGE : `PPP_FLASH_WB_SMALL;
  localparam int EWB = LARGE_PART ? `PPP_EEP_WB_LARGE : `PPP_EEP_WB_SMALL;
  localparam int STAB_CYC = `PPP_STABLE_CYC;

  typedef enum logic [2:0] {
    S_CAL_ISSUE, S_CAL_WAIT, S_IDLE, S_ISSUE, S_WAIT_DONE, S_WAIT_READ
  } ppp_state_t;

  ppp_state_t state, next_state;
  ppp_req_t pend, next_pend;
  ppp_pins_t pins_raw, pins_m, pins_s, pins_d;
  logic [23:0] addr;
  logic [7:0] cmd, data_lo, data_hi;
  logic page_open;
  logic [2:0] tog_cnt;
  logic stab_run;
  logic [4:0] stab_cnt;
  ppp_op_t wr_op, rd_op;
  logic wr_ok, rd_ok;
  ppp_req_t wr_req, rd_req, pl_req;
  logic [23:0] next_addr;
  logic next_busy;
  logic u_buf_ready;

  // Index bits of a page for the memory an operation touches.
  function automatic int unsigned word_bits(ppp_op_t op);
    if (op inside {OP_RD_FLASH, OP_LOAD_FLASH, OP_PROG_FLASH}) begin
      return FWB;
    end
    if (op inside {OP_RD_EEP, OP_LOAD_EEP, OP_PROG_EEP}) begin
      return EWB;
    end
    return 0;
  endfunction

  // Split an address into page and word; higher bits pick the page.
  function automatic ppp_req_t mk_req(ppp_op_t op, logic [1:0] sel, logic [23:0] a,
                                      logic [15:0] d);
    ppp_req_t r;
    int unsigned wb;
    wb = word_bits(op);
    r.op = op;
    r.sel = sel;
    r.page = a >> wb;
    r.word = 8'(a & ((24'h000001 << wb) - 24'h000001));
    r.data = d;
    return r;
  endfunction

  // Replace one address byte chosen by the byte-select pair.
  function automatic logic [23:0] set_byte(logic [23:0] a, logic [1:0] bs, logic [7:0] d);
    logic [23:0] r;
    r = a;
    unique case (bs)
      `PPP_BS_LOW: r[7:0] = d;
      `PPP_BS_HIGH: r[15:8] = d;
      `PPP_BS_EXT: r[23:16] = d;
      default: r = a;
    endcase
    return r;
  endfunction

  // Every pin is asynchronous, so all pass two flops; pins_d only feeds edge detection.
  assign pins_raw = '{rst_low: rst_pin_low_i, hv: rst_pin_hv_i, strobe: load_strobe_i,
                      act: {action_select_1_i, action_select_0_i},
                      bs_hi: byte_select_hi_i, bs_lo: byte_select_lo_i,
                      page_load: page_load_strobe_i, wr_n: wr_n_i, oe_n: oe_n_i,
                      data: data_i};

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pins_m <= '0;
      pins_s <= '0;
      pins_d <= '0;
    end else begin
      pins_m <= pins_raw;
      pins_s <= pins_m;
      pins_d <= pins_s;
    end
  end

  // Edge events and pin groups, all taken from synchronised copies.
  wire logic strobe_rise = pins_s.strobe & ~pins_d.strobe;
  wire logic pl_rise = pins_s.page_load & ~pins_d.page_load;
  wire logic wr_fall = ~pins_s.wr_n & pins_d.wr_n;
  wire logic oe_fall = ~pins_s.oe_n & pins_d.oe_n;
  wire logic hv_rise = pins_s.hv & ~pins_d.hv;
  wire logic bs_change = (pins_s.bs_lo != pins_d.bs_lo) || (pins_s.bs_hi != pins_d.bs_hi);
  wire logic [1:0] bsel = {pins_s.bs_hi, pins_s.bs_lo};
  wire logic [3:0] en_pins = {pins_s.page_load, pins_s.act, pins_s.bs_lo};
  wire logic stab_done = stab_run && (stab_cnt == 5'(STAB_CYC - 1));

  // Entry needs six strobes under low reset, then select pins held at zero after the
  // high voltage arrives; any wiggle in that window aborts and demands a fresh attempt.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tog_cnt <= 3'h0;
      stab_run <= 1'b0;
      stab_cnt <= 5'h00;
      prog_mode_o <= 1'b0;
    end else if (!pins_s.hv) begin
      stab_run <= 1'b0;
      prog_mode_o <= 1'b0;
      if (pins_s.rst_low && strobe_rise && tog_cnt != `PPP_ENTRY_TOGGLES) begin
        tog_cnt <= tog_cnt + 3'h1;
      end
    end else if (hv_rise) begin
      stab_run <= (tog_cnt == `PPP_ENTRY_TOGGLES) && (en_pins == 4'h0);
      stab_cnt <= 5'h00;
    end else if (stab_run) begin
      if (en_pins != 4'h0) begin
        stab_run <= 1'b0;
        tog_cnt <= 3'h0;
      end else if (stab_done) begin
        stab_run <= 1'b0;
        prog_mode_o <= 1'b1;
        tog_cnt <= 3'h0;
      end else begin
        stab_cnt <= stab_cnt + 5'h01;
      end
    end
  end

  // Command decode into memory operations.
  assign wr_op = (cmd == `PPP_CMD_ERASE) ? OP_ERASE_FLASH :
                 (cmd == `PPP_CMD_WR_FUSE) ? OP_WR_FUSE :
                 (cmd == `PPP_CMD_WR_LOCK) ? OP_WR_LOCK :
                 (cmd == `PPP_CMD_WR_EEP) ? OP_PROG_EEP : OP_PROG_FLASH;
  assign wr_ok = (cmd inside {`PPP_CMD_ERASE, `PPP_CMD_WR_FUSE, `PPP_CMD_WR_LOCK}) ||
                 ((cmd inside {`PPP_CMD_WR_FLASH, `PPP_CMD_WR_EEP}) && page_open);
  assign rd_op = (cmd == `PPP_CMD_RD_SIG) ? OP_RD_SIG :
                 (cmd == `PPP_CMD_RD_FUSE) ? OP_RD_FUSE :
                 (cmd == `PPP_CMD_RD_EEP) ? OP_RD_EEP : OP_RD_FLASH;
  assign rd_ok = cmd inside {`PPP_CMD_RD_SIG, `PPP_CMD_RD_FUSE, `PPP_CMD_RD_EEP,
                             `PPP_CMD_RD_FLASH};
  assign wr_req = mk_req(wr_op, bsel, addr, {8'h00, data_lo});
  assign rd_req = mk_req(rd_op, bsel, addr, 16'h0000);
  assign pl_req = mk_req((cmd == `PPP_CMD_WR_EEP) ? OP_LOAD_EEP : OP_LOAD_FLASH, bsel, addr,
                         {data_hi, data_lo});
  assign next_addr = set_byte(addr, bsel, pins_s.data);

  // Requests are taken only in programming mode and only when idle.
  wire logic idle_on = prog_mode_o && (state == S_IDLE);
  wire logic take_wr = idle_on && wr_fall && wr_ok;
  wire logic take_rd = idle_on && !take_wr && rd_ok &&
                       (oe_fall || (!pins_s.oe_n && bs_change));
  wire logic take_pl = idle_on && !take_wr && !take_rd && pl_rise && pins_s.bs_lo &&
                       (cmd inside {`PPP_CMD_WR_FLASH, `PPP_CMD_WR_EEP});
  wire logic prog_taken = take_wr && (wr_op inside {OP_PROG_FLASH, OP_PROG_EEP});

  // Strobe loads; command and address persist until the programmer reloads them.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      addr <= 24'h000000;
      cmd <= `PPP_CMD_NOOP;
      data_lo <= 8'h00;
      data_hi <= 8'h00;
      page_open <= 1'b0;
    end else begin
      if (prog_mode_o && strobe_rise) begin
        unique case (pins_s.act)
          `PPP_ACT_ADDR: addr <= next_addr;
          `PPP_ACT_DATA: begin
            if (pins_s.bs_lo) begin
              data_hi <= pins_s.data;
            end else begin
              data_lo <= pins_s.data;
            end
          end
          `PPP_ACT_CMD: cmd <= pins_s.data;
          `PPP_ACT_IDLE: ;
        endcase
      end
      if (take_pl) begin
        page_open <= 1'b1;
      end else if (prog_taken ||
                   (prog_mode_o && strobe_rise && pins_s.act == `PPP_ACT_CMD &&
                    pins_s.data == `PPP_CMD_NOOP)) begin
        page_open <= 1'b0;
      end
    end
  end

  // Sequencer; chip erase chains flash, optional EEPROM, then lock clear.
  always_comb begin
    next_state = state;
    next_pend = pend;
    unique case (state)
      S_CAL_ISSUE: if (u_buf_ready) next_state = S_CAL_WAIT;
      S_CAL_WAIT: if (mem_rvalid_i) next_state = S_IDLE;
      S_IDLE: begin
        if (take_wr) begin
          next_pend = wr_req;
          next_state = S_ISSUE;
        end else if (take_rd) begin
          next_pend = rd_req;
          next_state = S_ISSUE;
        end else if (take_pl) begin
          next_pend = pl_req;
          next_state = S_ISSUE;
        end
      end
      S_ISSUE: begin
        if (u_buf_ready) begin
          next_state = ppp_is_read(pend.op) ? S_WAIT_READ :
                       ppp_is_load(pend.op) ? S_IDLE : S_WAIT_DONE;
        end
      end
      S_WAIT_DONE: begin
        if (mem_done_i) begin
          next_state = S_ISSUE;
          if (pend.op == OP_ERASE_FLASH) begin
            next_pend.op = eeprom_preserve_fuse_n_i ? OP_ERASE_EEP : OP_CLEAR_LOCK;
          end else if (pend.op == OP_ERASE_EEP) begin
            next_pend.op = OP_CLEAR_LOCK;
          end else begin
            next_state = S_IDLE;
          end
        end
      end
      S_WAIT_READ: if (mem_rvalid_i) next_state = S_IDLE;
    endcase
  end

  assign next_busy = (next_state == S_WAIT_DONE) ||
                     (next_state == S_ISSUE && !ppp_is_read(next_pend.op) &&
                      !ppp_is_load(next_pend.op));

  // Reset leaves a signature read of the 3V calibration byte queued.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= S_CAL_ISSUE;
      pend <= '{op: OP_RD_SIG, sel: `PPP_BS_LOW, page: `PPP_CAL3V_ADDR, word: 8'h00,
                data: 16'h0000};
      ready_busy_out_o <= 1'b1;
    end else begin
      state <= next_state;
      pend <= next_pend;
      ready_busy_out_o <= !next_busy;
    end
  end

  // Returned bytes; the bus is driven only while output enable is low.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      osc_calibration_reg_o <= `PPP_OSC_CALIBRATION_REG_RST;
      data_o <= 8'h00;
      data_oe_o <= 1'b0;
    end else begin
      if (state == S_CAL_WAIT && mem_rvalid_i) osc_calibration_reg_o <= mem_rdata_i;
      if (state == S_WAIT_READ && mem_rvalid_i) data_o <= mem_rdata_i;
      data_oe_o <= prog_mode_o && !pins_s.oe_n;
    end
  end

  ppp_buf2 #(.W($bits(ppp_req_t))) u_buf (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .in_valid_i(state == S_ISSUE || state == S_CAL_ISSUE),
    .in_ready_o(u_buf_ready),
    .in_data_i(pend),
    .out_valid_o(mem_valid_o),
    .out_ready_i(mem_ready_i),
    .out_data_o(mem_req_o)
  );

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  property p_busy_on_write;
    take_wr |=> !ready_busy_out_o && state == S_ISSUE;
  endproperty
  a_busy_on_write: assert property (p_busy_on_write) else $error("busy not raised");

  property p_ready_after_done;
    state == S_WAIT_DONE && mem_done_i && !(pend.op inside {OP_ERASE_FLASH, OP_ERASE_EEP})
      |=> ready_busy_out_o;
  endproperty
  a_ready_after_done: assert property (p_ready_after_done) else $error("ready late");

  property p_oe_drive;
    !prog_mode_o || pins_s.oe_n |=> !data_oe_o;
  endproperty
  a_oe_drive: assert property (p_oe_drive) else $error("bus driven without enable");

  property p_cmd_load;
    prog_mode_o && strobe_rise && pins_s.act == `PPP_ACT_CMD |=> cmd == $past(pins_s.data);
  endproperty
  a_cmd_load: assert property (p_cmd_load) else $error("command not loaded");

  property p_addr_hold;
    !strobe_rise |=> $stable(addr) && $stable(cmd);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address or command moved");

  property p_ignore_outside;
    !prog_mode_o |=> state != S_ISSUE || $past(state) != S_IDLE;
  endproperty
  a_ignore_outside: assert property (p_ignore_outside) else $error("action outside mode");

  property p_entry_stable;
    $rose(prog_mode_o) |-> $past(stab_cnt) == 5'(STAB_CYC - 1) && $past(en_pins) == 4'h0;
  endproperty
  a_entry_stable: assert property (p_entry_stable) else $error("entry too early");

  property p_lock_last;
    $rose(pend.op == OP_CLEAR_LOCK) |-> $past(mem_done_i) && $past(state) == S_WAIT_DONE;
  endproperty
  a_lock_last: assert property (p_lock_last) else $error("locks cleared early");

  property p_preserve;
    $rose(pend.op == OP_ERASE_EEP) |-> $past(eeprom_preserve_fuse_n_i);
  endproperty
  a_preserve: assert property (p_preserve) else $error("preserved EEPROM erased");

  property p_cal_copy;
    state == S_CAL_WAIT && mem_rvalid_i |=> osc_calibration_reg_o == $past(mem_rdata_i);
  endproperty
  a_cal_copy: assert property (p_cal_copy) else $error("calibration not copied");

  property p_busy_ignore;
    state == S_WAIT_DONE && !mem_done_i |=> $stable(pend) ##0 state == S_WAIT_DONE;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("write taken while busy");
endmodule

/* dv/ppp_mem_model.sv */
// Purpose: Memory controller model on the far side of the programming port.
// Assumes: Shares mclk_i with the port; serves one request at a time.
// Notes: Loads end silently, reads answer with data, all other work with done.
module ppp_mem_model
  import ppp_pkg::*;
#(
  parameter logic [7:0] CAL3V = 8'h9C,
  parameter logic [7:0] CAL5V = 8'h63
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire ppp_pkg::ppp_req_t req_i,
  input wire logic valid_i,
  output logic ready_o,
  output logic done_o,
  output logic rvalid_o,
  output logic [7:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int lat = 2;
  int cnt;
  ppp_req_t cur;
  ppp_req_t log_q[$];
  // Ready is offered only when idle; lat sets how slowly each request is served.
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
      done_o <= 1'b0;
      rvalid_o <= 1'b0;
      rdata_o <= 8'h00;
      cnt <= 0;
    end else begin
      done_o <= 1'b0;
      rvalid_o <= 1'b0;
      rdata_o <= ~rdata_o; // Idle read data toggles so no stale byte looks valid.
      ready_o <= valid_i && !ready_o && cnt == 0;
      if (valid_i && ready_o) begin
        cur <= req_i;
        log_q.push_back(req_i);
        cnt <= lat;
      end else if (cnt == 1) begin
        cnt <= 0;
        if (cur.op inside {OP_RD_FLASH, OP_RD_EEP, OP_RD_SIG, OP_RD_FUSE}) begin
          rvalid_o <= 1'b1;
          rdata_o <= cur.page[7:0] ^ cur.word;
          if (cur.op == OP_RD_SIG && cur.page == 24'h000001) rdata_o <= CAL3V;
          if (cur.op == OP_RD_SIG && cur.page == 24'h000003) rdata_o <= CAL5V;
        end else if (!(cur.op inside {OP_LOAD_FLASH, OP_LOAD_EEP})) begin
          done_o <= 1'b1;
        end
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

/* dv/tb_top.sv */
// Purpose: Self-checking bench for the parallel programming port.
// Assumes: Small part pages; pins held 32 cycles per step.
// Notes: Read results are noted in exp_q and compared by a watcher process.
`include "ppp_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ppp_pkg::*;
  localparam int PW = 32; // 256 ns per pin step.
  logic mclk_i = 1'b0;
  logic rst_i;
  logic eeprom_preserve_fuse_n_i;
  ppp_pins_t p;
  logic [7:0] data_o;
  logic data_oe_o, ready_busy_out_o, prog_mode_o;
  logic [7:0] osc_calibration_reg_o, mem_rdata_i;
  ppp_req_t mem_req_o;
  logic mem_valid_o, mem_ready_i, mem_done_i, mem_rvalid_i;
  logic [31:0] lf = 32'h2C05F72D;
  logic [7:0] exp_q[$];
  logic rv_d = 1'b0;
  int err_total = 0;
  int total_checks = 0;
  // The shared data wire carries the device byte only while it drives.
  wire logic [7:0] data_i = data_oe_o ? data_o : p.data;
  always #4 mclk_i = ~mclk_i;
  ppp_port #(.LARGE_PART(1'b0)) DUT (.mclk_i, .rst_i, .rst_pin_low_i(p.rst_low),
    .rst_pin_hv_i(p.hv), .load_strobe_i(p.strobe), .action_select_0_i(p.act[0]),
    .action_select_1_i(p.act[1]), .byte_select_lo_i(p.bs_lo), .byte_select_hi_i(p.bs_hi),
    .page_load_strobe_i(p.page_load), .wr_n_i(p.wr_n), .oe_n_i(p.oe_n), .data_i, .data_o,
    .data_oe_o, .ready_busy_out_o, .prog_mode_o, .osc_calibration_reg_o,
    .eeprom_preserve_fuse_n_i, .mem_req_o, .mem_valid_o, .mem_ready_i, .mem_done_i,
    .mem_rvalid_i, .mem_rdata_i);
  ppp_mem_model pm (.mclk_i, .rst_i, .req_i(mem_req_o), .valid_i(mem_valid_o),
    .ready_o(mem_ready_i), .done_o(mem_done_i), .rvalid_o(mem_rvalid_i),
    .rdata_o(mem_rdata_i));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic step(int n = PW);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (e !== g) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One strobe load: set action, byte select and data, then pulse the strobe.
  task automatic ld(logic [1:0] act, logic [1:0] bs, logic [7:0] d);
    p.act <= act;
    {p.bs_hi, p.bs_lo} <= bs;
    p.data <= d;
    step();
    p.strobe <= 1'b1;
    step();
    p.strobe <= 1'b0;
    step();
  endtask
  task automatic wr();
    p.wr_n <= 1'b0;
    step();
    p.wr_n <= 1'b1;
    step();
  endtask
  // Page-load pulse with the high byte selected, then back to the low byte.
  task automatic pl();
    p.bs_lo <= 1'b1;
    p.page_load <= 1'b1;
    step();
    p.page_load <= 1'b0;
    p.bs_lo <= 1'b0;
    step();
  endtask
  task automatic rd();
    p.oe_n <= 1'b0;
    step();
    chk("data_oe_on", 1, data_oe_o);
    p.oe_n <= 1'b1;
    step();
    chk("data_oe_off", 0, data_oe_o);
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 3000 && ready_busy_out_o !== 1'b1; i++) @(posedge mclk_i);
    chk("ready", 1, ready_busy_out_o);
  endtask
  // Six strobes with reset low, select pins 0000, then high voltage.
  task automatic enter(bit abort);
    p.rst_low <= 1'b1;
    repeat (6) begin
      p.strobe <= 1'b1;
      step();
      p.strobe <= 1'b0;
      step();
    end
    {p.page_load, p.act, p.bs_lo} <= 4'h0;
    step();
    p.rst_low <= 1'b0;
    p.hv <= 1'b1;
    step(5);
    if (abort) p.bs_lo <= 1'b1;
    step();
    chk("prog_mode", !abort, prog_mode_o);
    p.hv <= !abort;
    p.bs_lo <= 1'b0;
    step();
  endtask
  // A result shows on data_o the cycle after the memory answers.
  always @(posedge mclk_i) begin
    rv_d <= mem_rvalid_i && prog_mode_o;
    if (rv_d) begin
      chk("data_o", exp_q.pop_front(), data_o);
    end
  end
  initial begin
    step(60000);
    err_total++;
    report_and_stop();
  end
  initial begin
    logic [15:0] a;
    logic [23:0] pg;
    logic [7:0] wd, lo, hi;
    int wb;
    p = '0;
    p.wr_n = 1'b1;
    p.oe_n = 1'b1;
    rst_i = 1'b1;
    eeprom_preserve_fuse_n_i = 1'b1;
    step(3);
    rst_i <= 1'b0;
    // The calibration read needs several cycles of memory latency to come back.
    step(10);
    chk("osc", 8'h9C, osc_calibration_reg_o);
    chk("cal_page", 24'h000001, pm.log_q[0].page);
    ld(`PPP_ACT_CMD, `PPP_BS_LOW, `PPP_CMD_ERASE);
    wr();
    chk("early_ops", 1, pm.log_q.size());
    enter(1'b1);
    enter(1'b0);
    step(6250);
    for (int f = 1; f >= 0; f--) begin
      eeprom_preserve_fuse_n_i <= f[0];
      pm.lat = 100;
      pm.log_q.delete();
      ld(`PPP_ACT_CMD, `PPP_BS_LOW, `PPP_CMD_ERASE);
      wr();
      chk("busy", 0, ready_busy_out_o);
      wr();
      wait_ready();
      chk("erase_ops", 2 + f, pm.log_q.size());
      chk("erase_first", OP_ERASE_FLASH, pm.log_q[0].op);
      chk("erase_mid", f ? OP_ERASE_EEP : OP_CLEAR_LOCK, pm.log_q[1].op);
      chk("erase_last", OP_CLEAR_LOCK, pm.log_q[$].op);
    end
    pm.lat = 2;
    for (int m = 0; m < 2; m++) begin
      lf = lfsr(lf);
      a = lf[15:0];
      lo = lf[23:16] & 8'h7F;
      hi = lf[31:24] & 8'h7F;
      wb = m ? `PPP_EEP_WB_SMALL : `PPP_FLASH_WB_SMALL;
      pm.log_q.delete();
      ld(`PPP_ACT_CMD, `PPP_BS_LOW, m ? `PPP_CMD_WR_EEP : `PPP_CMD_WR_FLASH);
      ld(`PPP_ACT_ADDR, `PPP_BS_EXT, 8'h00);
      ld(`PPP_ACT_ADDR, `PPP_BS_HIGH, a[15:8]);
      ld(`PPP_ACT_ADDR, `PPP_BS_LOW, a[7:0]);
      ld(`PPP_ACT_DATA, `PPP_BS_LOW, lo);
      ld(`PPP_ACT_DATA, `PPP_BS_HIGH, hi);
      pl();
      wr();
      wait_ready();
      // A fresh latch followed by the no-op command must leave nothing to program.
      pl();
      ld(`PPP_ACT_CMD, `PPP_BS_LOW, `PPP_CMD_NOOP);
      ld(`PPP_ACT_CMD, `PPP_BS_LOW, m ? `PPP_CMD_WR_EEP : `PPP_CMD_WR_FLASH);
      wr();
      pg = {8'h00, a} >> wb;
      wd = a & ((16'h1 << wb) - 16'h1);
      chk("load_op", m ? OP_LOAD_EEP : OP_LOAD_FLASH, pm.log_q[0].op);
      chk("load_page", pg, pm.log_q[0].page);
      chk("load_word", wd, pm.log_q[0].word);
      chk("load_data", {hi, lo}, pm.log_q[0].data);
      chk("prog_op", m ? OP_PROG_EEP : OP_PROG_FLASH, pm.log_q[1].op);
      chk("prog_page", pg, pm.log_q[1].page);
      chk("noop_ops", 3, pm.log_q.size());
    end
    // Fuse and lock writes carry the low data byte and need no page latch.
    for (int j = 0; j < 2; j++) begin
      lf = lfsr(lf);
      pm.log_q.delete();
      ld(`PPP_ACT_CMD, `PPP_BS_LOW, j ? `PPP_CMD_WR_LOCK : `PPP_CMD_WR_FUSE);
      ld(`PPP_ACT_DATA, `PPP_BS_LOW, lf[7:0]);
      wr();
      wait_ready();
      chk("fuse_op", j ? OP_WR_LOCK : OP_WR_FUSE, pm.log_q[0].op);
      chk("fuse_sel", `PPP_BS_LOW, pm.log_q[0].sel);
      chk("fuse_data", {8'h00, lf[7:0]}, pm.log_q[0].data);
    end
    for (int k = 0; k < 4; k++) begin
      lf = lfsr(lf);
      a = (k == 2) ? 16'h0003 : lf[15:0];
      wb = (k == 0) ? 6 : (k == 1) ? 2 : 0;
      pm.log_q.delete();
      ld(`PPP_ACT_CMD, `PPP_BS_LOW, k[1] ? (k[0] ? `PPP_CMD_RD_FUSE : `PPP_CMD_RD_SIG)
        : (k[0] ? `PPP_CMD_RD_EEP : `PPP_CMD_RD_FLASH));
      ld(`PPP_ACT_ADDR, `PPP_BS_HIGH, a[15:8]);
      ld(`PPP_ACT_ADDR, `PPP_BS_LOW, a[7:0]);
      pg = {8'h00, a} >> wb;
      wd = a & ((16'h1 << wb) - 16'h1);
      repeat (2) exp_q.push_back((k == 2) ? 8'h63 : pg[7:0] ^ wd);
      rd();
      rd();
      chk("read_op", k, pm.log_q[1].op);
    end
    chk("pending", 0, exp_q.size());
    report_and_stop();
  end
endmodule
